// ==== design/acsp_consts.vh ====
// Purpose: constants for the converter serial configuration port
// Assumes: 8-bit frames, address byte = {A[7:1], R/W}
// Notes: offsets are register byte addresses with the R/W bit clear
`ifndef ACSP_CONSTS_VH
`define ACSP_CONSTS_VH

// frame layout
`define ACSP_FRAME_BITS 4'h8
`define ACSP_LAST_BIT 3'h7
`define ACSP_RW_READ 1'b1

// register offsets
`define ACSP_OFF_TOP 8'h00
`define ACSP_OFF_OVERLOAD 8'h04
`define ACSP_OFF_PAT_LOW 8'h10
`define ACSP_OFF_PAT_HIGH 8'h12
`define ACSP_OFF_CLIPPING 8'h14
`define ACSP_OFF_DECIMATOR 8'h16
`define ACSP_OFF_LVDS 8'h18

// reset values
`define ACSP_RST_REG 8'h00

// top control fields
`define ACSP_TOP_READBACK 5
`define ACSP_TOP_OPEN_DRAIN 2
`define ACSP_TOP_MASK 8'h3F

// overload control fields
`define ACSP_OVL_RECOVERY 4
`define ACSP_OVL_CLIP_HI 3
`define ACSP_OVL_CLIP_LO 0
`define ACSP_OVL_MASK 8'h1F

// clipping control fields
`define ACSP_CLP_CUSTOM 7
`define ACSP_CLP_GAIN_HI 2
`define ACSP_CLP_GAIN_LO 0
`define ACSP_CLP_MASK 8'hBF

// decimator control fields
`define ACSP_DEC_TRAIN_HI 1
`define ACSP_DEC_TRAIN_LO 0
`define ACSP_DEC_MASK 8'h1F
`define ACSP_TRAIN_NORMAL 2'h0

// pattern high byte holds pattern bits 11:8
`define ACSP_PATH_MASK 8'h0F

// lvds control fields
`define ACSP_LVDS_TERM 4
`define ACSP_LVDS_DRIVE_HI 3
`define ACSP_LVDS_DRIVE_LO 2
`define ACSP_LVDS_CM 1
`define ACSP_LVDS_SLVS 0
`define ACSP_LVDS_MASK 8'h1F

// recovery-mode defaults
`define ACSP_DEF_CLIP 4'h0
`define ACSP_DEF_GAIN 3'h0

`endif

// ==== design/acsp_serial_port.v ====
// Purpose: three-wire serial configuration port and its registers
// Assumes: host samples/drives on serial clock; device samples on rising
//          edge and changes its read data after the falling edge
// Notes: all pins pass a two-flop synchroniser into i_clk
//
// Behaviour
// - each frame is eight address/direction bits then eight data bits
// - last address bit low means write, high means read
// - address and data travel msb first; device returns read data
// - serial activity is ignored while select is high
// - select toggling never resets configuration registers
// - in open-drain mode the device only drives the line low
// - raising select early abandons the transaction
// - three training modes put one pattern on all eight channels
// - word and bit clocks keep running during training
// - training mode comes from the decimator control training field
// - two fixed patterns; custom pattern from two pattern registers
// - training field back to zero restores normal converter data
// - recovery enable bit turns on recovery with clip level from the overload clip field
// - clearing recovery enable returns gain and clip to defaults
// - custom gain applies only while custom gain select is set
// - lvds control selects drive current, lowest by default
// - termination bit set enables on-chip transmitter termination
// - common-mode bit one selects standard lvds level
// - common-mode bit zero selects reduced lvds level
`timescale 1ns/1ps
`include "acsp_consts.vh"

module acsp_serial_port
(
  input wire i_clk,
  input wire i_nrst,
  input wire i_sclk,
  input wire i_ssel_n,
  input wire i_serial_data_line,
  output reg o_serial_data_line,
  output reg o_serial_data_line_oe,
  output reg o_open_drain_select,
  output reg [1:0] o_training_select,
  output reg o_training_active,
  output reg [11:0] o_training_pattern,
  output reg o_overload_recovery_enable,
  output reg [3:0] o_analog_clip_level,
  output reg [2:0] o_digital_gain_field,
  output reg [1:0] o_drive_current,
  output reg o_tx_termination,
  output reg o_output_common_mode_select,
  output reg o_slvs_mode
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_ADDR = 3'b010;
  localparam [2:0] ST_DATA = 3'b100;

  // pin synchronisers; stage one feeds only stage two
  reg sclk_s1_ff;
  reg sclk_s2_ff;
  reg sclk_s3_ff;
  reg ssel_s1_ff;
  reg ssel_s2_ff;
  reg sdi_s1_ff;
  reg sdi_s2_ff;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [2:0] cnt_ff;
  reg [2:0] nxt_cnt;
  reg [7:0] shin_ff;
  reg [7:0] nxt_shin;
  reg [7:0] addr_ff;
  reg [7:0] nxt_addr;
  reg [7:0] tx_ff;
  reg [7:0] nxt_tx;
  reg drive_ff;
  reg nxt_drive;

  reg [7:0] top_ff;
  reg [7:0] ovl_ff;
  reg [7:0] patl_ff;
  reg [7:0] path_ff;
  reg [7:0] clp_ff;
  reg [7:0] dec_ff;
  reg [7:0] lvds_ff;

  reg wr_en;
  reg [7:0] wr_off;
  reg [7:0] wr_data;
  reg [7:0] rd_data;
  reg bit_out;

  wire sclk_rise;
  wire sclk_fall;
  wire selected;
  wire [7:0] rx_byte;
  wire [7:0] rd_off;
  wire readback;

  assign sclk_rise = sclk_s2_ff & ~sclk_s3_ff;
  assign sclk_fall = ~sclk_s2_ff & sclk_s3_ff;
  assign selected = ~ssel_s2_ff;
  assign rx_byte = {shin_ff[6:0], sdi_s2_ff};
  assign rd_off = {rx_byte[7:1], 1'b0};
  assign readback = top_ff[`ACSP_TOP_READBACK];

  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      sclk_s3_ff <= 1'b0;
      ssel_s1_ff <= 1'b1;
      ssel_s2_ff <= 1'b1;
      sdi_s1_ff <= 1'b0;
      sdi_s2_ff <= 1'b0;
    end
    else
    begin
      sclk_s1_ff <= i_sclk;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_s3_ff <= sclk_s2_ff;
      ssel_s1_ff <= i_ssel_n;
      ssel_s2_ff <= ssel_s1_ff;
      sdi_s1_ff <= i_serial_data_line;
      sdi_s2_ff <= sdi_s1_ff;
    end
  end

  // read mux: top control readable only with readback set, others without
  always @*
  begin
    rd_data = `ACSP_RST_REG;
    case (rd_off)
      `ACSP_OFF_TOP:
        rd_data = readback ? top_ff : `ACSP_RST_REG;
      `ACSP_OFF_OVERLOAD:
        rd_data = readback ? `ACSP_RST_REG : ovl_ff;
      `ACSP_OFF_PAT_LOW:
        rd_data = readback ? `ACSP_RST_REG : patl_ff;
      `ACSP_OFF_PAT_HIGH:
        rd_data = readback ? `ACSP_RST_REG : path_ff;
      `ACSP_OFF_CLIPPING:
        rd_data = readback ? `ACSP_RST_REG : clp_ff;
      `ACSP_OFF_DECIMATOR:
        rd_data = readback ? `ACSP_RST_REG : dec_ff;
      `ACSP_OFF_LVDS:
        rd_data = readback ? `ACSP_RST_REG : lvds_ff;
      default:
        rd_data = `ACSP_RST_REG;
    endcase
  end

  // frame sequencer
  always @*
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_shin = shin_ff;
    nxt_addr = addr_ff;
    nxt_tx = tx_ff;
    nxt_drive = drive_ff;
    wr_en = 1'b0;
    wr_off = {addr_ff[7:1], 1'b0};
    wr_data = rx_byte;
    case (state_ff)
      ST_IDLE:
      begin
        nxt_cnt = 3'h0;
        nxt_drive = 1'b0;
        if (selected)
          nxt_state = ST_ADDR;
      end
      ST_ADDR:
      begin
        if (!selected)
          nxt_state = ST_IDLE;
        else if (sclk_rise)
        begin
          nxt_shin = rx_byte;
          nxt_cnt = cnt_ff + 3'h1;
          if (cnt_ff == `ACSP_LAST_BIT)
          begin
            nxt_addr = rx_byte;
            nxt_tx = rd_data;
            nxt_cnt = 3'h0;
            nxt_state = ST_DATA;
          end
        end
      end
      ST_DATA:
      begin
        if (!selected)
        begin
          nxt_state = ST_IDLE;
          nxt_drive = 1'b0;
        end
        else if (sclk_rise)
        begin
          nxt_shin = rx_byte;
          nxt_cnt = cnt_ff + 3'h1;
          if (cnt_ff == `ACSP_LAST_BIT)
          begin
            // last data bit: writes commit here, never earlier
            wr_en = (addr_ff[0] != `ACSP_RW_READ);
            nxt_state = ST_IDLE;
            nxt_drive = 1'b0;
          end
        end
        else if (sclk_fall && addr_ff[0] == `ACSP_RW_READ)
        begin
          nxt_drive = 1'b1;
          nxt_tx = {tx_ff[6:0], 1'b0};
        end
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= 3'h0;
      shin_ff <= 8'h00;
      addr_ff <= 8'h00;
      tx_ff <= 8'h00;
      drive_ff <= 1'b0;
      bit_out <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      shin_ff <= nxt_shin;
      addr_ff <= nxt_addr;
      tx_ff <= nxt_tx;
      drive_ff <= nxt_drive;
      if (sclk_fall && state_ff == ST_DATA)
        bit_out <= tx_ff[7];
    end
  end

  // configuration registers; only the chip reset clears them
  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      top_ff <= `ACSP_RST_REG;
      ovl_ff <= `ACSP_RST_REG;
      patl_ff <= `ACSP_RST_REG;
      path_ff <= `ACSP_RST_REG;
      clp_ff <= `ACSP_RST_REG;
      dec_ff <= `ACSP_RST_REG;
      lvds_ff <= `ACSP_RST_REG;
    end
    else if (wr_en)
    begin
      case (wr_off)
        `ACSP_OFF_TOP:
          top_ff <= wr_data & `ACSP_TOP_MASK;
        `ACSP_OFF_OVERLOAD:
          ovl_ff <= wr_data & `ACSP_OVL_MASK;
        `ACSP_OFF_PAT_LOW:
          patl_ff <= wr_data;
        `ACSP_OFF_PAT_HIGH:
          path_ff <= wr_data & `ACSP_PATH_MASK;
        `ACSP_OFF_CLIPPING:
          clp_ff <= wr_data & `ACSP_CLP_MASK;
        `ACSP_OFF_DECIMATOR:
          dec_ff <= wr_data & `ACSP_DEC_MASK;
        `ACSP_OFF_LVDS:
          lvds_ff <= wr_data & `ACSP_LVDS_MASK;
        default:
          top_ff <= top_ff;
      endcase
    end
  end

  // pin driver and configuration outputs, all registered
  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_serial_data_line <= 1'b0;
      o_serial_data_line_oe <= 1'b0;
      o_open_drain_select <= 1'b0;
      o_training_select <= `ACSP_TRAIN_NORMAL;
      o_training_active <= 1'b0;
      o_training_pattern <= 12'h000;
      o_overload_recovery_enable <= 1'b0;
      o_analog_clip_level <= `ACSP_DEF_CLIP;
      o_digital_gain_field <= `ACSP_DEF_GAIN;
      o_drive_current <= 2'h0;
      o_tx_termination <= 1'b0;
      o_output_common_mode_select <= 1'b0;
      o_slvs_mode <= 1'b0;
    end
    else
    begin
      o_open_drain_select <= top_ff[`ACSP_TOP_OPEN_DRAIN];
      if (top_ff[`ACSP_TOP_OPEN_DRAIN])
      begin
        o_serial_data_line <= 1'b0;
        o_serial_data_line_oe <= drive_ff & selected & ~bit_out;
      end
      else
      begin
        o_serial_data_line <= bit_out;
        o_serial_data_line_oe <= drive_ff & selected;
      end
      // datapath keeps word and bit clocks running in every mode
      o_training_select <=
        dec_ff[`ACSP_DEC_TRAIN_HI:`ACSP_DEC_TRAIN_LO];
      o_training_active <= (dec_ff[`ACSP_DEC_TRAIN_HI:`ACSP_DEC_TRAIN_LO]
        != `ACSP_TRAIN_NORMAL);
      o_training_pattern <= {path_ff[3:0], patl_ff};
      o_overload_recovery_enable <= ovl_ff[`ACSP_OVL_RECOVERY];
      o_analog_clip_level <= ovl_ff[`ACSP_OVL_RECOVERY] ?
        ovl_ff[`ACSP_OVL_CLIP_HI:`ACSP_OVL_CLIP_LO] :
        `ACSP_DEF_CLIP;
      o_digital_gain_field <=
        (ovl_ff[`ACSP_OVL_RECOVERY] & clp_ff[`ACSP_CLP_CUSTOM]) ?
        clp_ff[`ACSP_CLP_GAIN_HI:`ACSP_CLP_GAIN_LO] :
        `ACSP_DEF_GAIN;
      o_drive_current <=
        lvds_ff[`ACSP_LVDS_DRIVE_HI:`ACSP_LVDS_DRIVE_LO];
      o_tx_termination <= lvds_ff[`ACSP_LVDS_TERM];
      o_output_common_mode_select <= lvds_ff[`ACSP_LVDS_CM];
      o_slvs_mode <= lvds_ff[`ACSP_LVDS_SLVS];
    end
  end

endmodule

// ==== sim/acsp_host_model.sv ====
// Purpose: serial host driving three-wire frames
// Assumes: serial clock idles low, 8 clocks per bit
// Notes: pull-up on the data line while nobody drives
`timescale 1ns/1ps
module acsp_host_model
(
  input wire i_clk,
  input wire i_dev_oe,
  input wire i_dev_data,
  output logic o_sclk,
  output logic o_ssel_n,
  output wire o_line
);
  logic drv = 1'b1;
  initial
  begin
    o_sclk = 1'b0;
    o_ssel_n = 1'b1;
  end
  // released line floats to the pull-up level
  assign o_line = i_dev_oe ? i_dev_data : drv;
  task automatic bits(input logic [7:0] v, input logic rel, input int n,
    output logic [7:0] q);
    for (int i = 7; i > 7 - n; i--)
    begin
      drv <= rel ? 1'b1 : v[i];
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b1;
      // sample mid high phase, clear of the device's output updates
      repeat (2) @(posedge i_clk);
      q[i] = o_line;
      repeat (2) @(posedge i_clk);
      o_sclk <= 1'b0;
    end
  endtask
  task automatic frame(input logic [7:0] adr, input logic [7:0] wd,
    input int nd, output logic [7:0] q);
    logic [7:0] junk;
    o_ssel_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    bits(adr, 1'b0, 8, junk);
    bits(wd, adr[0], nd, q);
    repeat (4) @(posedge i_clk);
    o_ssel_n <= 1'b1;
    drv <= 1'b1;
    repeat (8) @(posedge i_clk);
  endtask
endmodule

// ==== sim/acsp_serial_port_bench.sv ====
// Purpose: self-checking bench of the configuration port
// Assumes: host model makes every frame
// Notes: outputs are read after each frame has ended
`timescale 1ns/1ps
module acsp_serial_port_bench;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  wire sclk, ssel_n, line, d_out, d_oe, od, act, rec, term, cm, slvs;
  wire [1:0] tmode, drv;
  wire [11:0] pat;
  wire [3:0] clip;
  wire [2:0] gain;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [7:0] q;
  always #10 i_clk = ~i_clk;
  acsp_serial_port u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_sclk(sclk),
    .i_ssel_n(ssel_n), .i_serial_data_line(line),
    .o_serial_data_line(d_out), .o_serial_data_line_oe(d_oe),
    .o_open_drain_select(od), .o_training_select(tmode),
    .o_training_active(act), .o_training_pattern(pat),
    .o_overload_recovery_enable(rec), .o_analog_clip_level(clip),
    .o_digital_gain_field(gain), .o_drive_current(drv),
    .o_tx_termination(term), .o_output_common_mode_select(cm),
    .o_slvs_mode(slvs));
  acsp_host_model u_host (.i_clk(i_clk), .i_dev_oe(d_oe),
    .i_dev_data(d_out), .o_sclk(sclk), .o_ssel_n(ssel_n), .o_line(line));
  task automatic chk(input logic [11:0] s, input logic [11:0] e);
    cmp_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.frame(a, d, 8, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    u_host.frame(a | 8'h01, 8'h00, 8, q);
    chk({4'h0, q}, {4'h0, e});
  endtask
  task automatic end_of_test;
    $display("comparisons %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic t_reset;
    chk({d_oe, od, tmode, act, rec, clip, term, cm}, 12'h000);
    chk({6'h0, drv, gain, slvs}, 12'h000);
    chk(pat, 12'h000);
    for (int a = 4; a < 26; a += 2)
      rd(8'(a), 8'h00);
  endtask
  task automatic t_lvds;
    logic [7:0] b;
    for (int i = 0; i < 3; i++)
    begin
      b = {3'h0, i[0], i[1:0], ~i[0], i[1]};
      wr(8'h18, b);
      chk({7'h0, term, drv, cm, slvs}, {7'h0, b[4:0]});
      rd(8'h18, b);
    end
  endtask
  task automatic t_train;
    wr(8'h10, 8'hA5);
    wr(8'h12, 8'hFC);
    rd(8'h12, 8'h0C);
    chk(pat, 12'hCA5);
    for (int i = 1; i < 4; i++)
    begin
      wr(8'h16, 8'(i));
      chk({9'h0, act, tmode}, {9'h0, 1'b1, 2'(i)});
    end
    wr(8'h16, 8'h00);
    chk({9'h0, act, tmode}, 12'h000);
  endtask
  task automatic t_recov;
    wr(8'h04, 8'h1A);
    wr(8'h14, 8'h05);
    chk({4'h0, rec, clip, gain}, 12'h0D0);
    wr(8'h14, 8'h85);
    chk({4'h0, rec, clip, gain}, 12'h0D5);
    wr(8'h04, 8'h0A);
    chk({4'h0, rec, clip, gain}, 12'h000);
  endtask
  task automatic t_abort;
    u_host.frame(8'h04, 8'h1F, 4, q);
    rd(8'h04, 8'h0A);
    wr(8'h08, 8'hFF);
    rd(8'h08, 8'h00);
  endtask
  task automatic t_odrain;
    wr(8'h00, 8'h24);
    chk({11'h0, od}, 12'h001);
    rd(8'h00, 8'h24);
    rd(8'h14, 8'h00);
    wr(8'h00, 8'h04);
    chk({11'h0, od}, 12'h001);
    rd(8'h00, 8'h00);
    wr(8'h00, 8'h00);
    chk({11'h0, od}, 12'h000);
    rd(8'h14, 8'h85);
  endtask
  initial
  begin
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (5) @(posedge i_clk);
    t_reset;
    t_lvds;
    t_train;
    t_recov;
    t_abort;
    t_odrain;
    end_of_test;
  end
  initial
  begin
    #400000;
    error_cnt++;
    end_of_test;
  end
endmodule

// ==== sim/acsp_serial_port_sva.sv ====
// Purpose: port-level checks of the configuration port
// Assumes: select passes a synchroniser first
// Notes: attached by bind
`timescale 1ns/1ps
module acsp_serial_port_chk
(
  input wire i_clk,
  input wire i_nrst,
  input wire i_sclk,
  input wire i_ssel_n,
  input wire i_serial_data_line,
  input wire o_serial_data_line,
  input wire o_serial_data_line_oe,
  input wire o_open_drain_select,
  input wire [1:0] o_training_select,
  input wire o_training_active,
  input wire [11:0] o_training_pattern,
  input wire o_overload_recovery_enable,
  input wire [3:0] o_analog_clip_level,
  input wire [2:0] o_digital_gain_field,
  input wire [1:0] o_drive_current,
  input wire o_tx_termination,
  input wire o_output_common_mode_select,
  input wire o_slvs_mode
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic [6:0] oe_cnt_ff;
  always @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
      oe_cnt_ff <= 7'h00;
    else
      oe_cnt_ff <= o_serial_data_line_oe ? oe_cnt_ff + 7'h01 : 7'h00;
  sequence s_idle;
    i_ssel_n [*6];
  endsequence
  sequence s_off;
    !o_overload_recovery_enable [*2];
  endsequence
  property p_quiet;
    s_idle |-> !o_serial_data_line_oe;
  endproperty
  property p_hold;
    s_idle |-> $stable({o_open_drain_select, o_training_select,
      o_training_pattern, o_overload_recovery_enable, o_drive_current,
      o_tx_termination, o_output_common_mode_select, o_slvs_mode});
  endproperty
  property p_od;
    o_open_drain_select && o_serial_data_line_oe |-> !o_serial_data_line;
  endproperty
  property p_oe_start;
    $rose(o_serial_data_line_oe) |-> !$past(i_ssel_n, 3);
  endproperty
  property p_oe_len;
    oe_cnt_ff <= 7'h48;
  endproperty
  property p_act;
    o_training_select != 2'h0 |-> ##[0:1] o_training_active;
  endproperty
  property p_norm;
    o_training_select == 2'h0 |-> ##[0:1] !o_training_active;
  endproperty
  property p_gate;
    s_off |-> o_analog_clip_level == 4'h0 && o_digital_gain_field == 3'h0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("drive while idle");
  a_hold: assert property (p_hold) else $error("config moved");
  a_od: assert property (p_od) else $error("drove high");
  a_oe_start: assert property (p_oe_start) else $error("oe early");
  a_oe_len: assert property (p_oe_len) else $error("oe too long");
  a_act: assert property (p_act) else $error("training off");
  a_norm: assert property (p_norm) else $error("training on");
  a_gate: assert property (p_gate) else $error("no defaults");
endmodule
bind acsp_serial_port acsp_serial_port_chk u_chk (.*);
